// File: shared/adc_seq_pkg.sv
/*
 * Constants for the conversion sequencer: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 40 MHz system clock and an AXI4-Lite register bus with 32-bit data.
 */
package adc_seq_pkg;

	// ----------------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------------
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] RESULT_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	// ----------------------------------------------------------------------
	// Mode register fields and reset values
	// ----------------------------------------------------------------------
	localparam int MODE_RUN_BIT = 0;
	localparam int MODE_HW_START_BIT = 1;
	localparam int MODE_SCAN_BIT = 2;
	localparam int MODE_CHAN_LSB = 4;
	localparam int MODE_WIDTH = 7;
	localparam logic [6:0] MODE_RESET = 7'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int CONV_TIME_NS = 10000;
	localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
	localparam int CYCLES_PER_BIT = CONV_CYCLES / 8;

endpackage : adc_seq_pkg

// File: logic/adc_conversion_sequencer.sv
/*
 * Conversion sequencer for an eight-channel successive-approximation converter,
 * with an AXI4-Lite register slave.
 * Assumes the analog comparator outside: it compares the selected input with
 * the trial code on dac_code_o and answers on cmp_i in the same cycle.
 */
// Notes on behaviour
// - Eight analog inputs share one converter and exactly one is selected at a time.
// - Each conversion is successive approximation and its 8-bit value is kept readable.
// - One conversion lasts about ten microseconds, counted in clock cycles.
// - In hardware-start mode a rising edge on the trigger pin starts conversion.
// - In software-start mode setting the run bit of the mode register starts conversion.
// - In scan mode channels 0 up to the channel field of the mode register are converted one after another.
// - In select mode one chosen channel is converted again and again.
// - The mode register picks start method, scan or select, and stops conversion.
// - A done pulse is raised each time a value enters the result register.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
	parameter int CHANNELS = 8,
	parameter int RES_BITS = 8
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// AXI4-Lite write channels.
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels.
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Converter side.
	input wire logic external_trigger_pin_i,
	input wire logic cmp_i,
	output logic [7:0] analog_input_pins_sel_o,
	output logic [7:0] dac_code_o,
	output logic conversion_done_interrupt_o
);

	// ----------------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------------
	// Refuses, at elaboration, any size that the fixed eight-bit datapath cannot serve.
	if (CHANNELS != 8 || RES_BITS != 8) begin : g_param_check
		$error("Only eight channels of eight bits are supported.");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [6:0] mode;
		logic [7:0] result;
		conv_state_t state;
		logic [2:0] chan;
		logic [2:0] bit_idx;
		logic [7:0] sar;
		logic [7:0] cyc;
		logic trig_prev;
		logic [7:0] sel;
		logic [7:0] code;
		logic done;
	} state_t;

	state_t cur_ff;
	state_t nxt_ff;

	logic [2:0] mode_chan;
	logic mode_run;
	logic mode_hw;
	logic mode_scan;
	assign mode_chan = cur_ff.mode[adc_seq_pkg::MODE_CHAN_LSB +: 3];
	assign mode_run = cur_ff.mode[adc_seq_pkg::MODE_RUN_BIT];
	assign mode_hw = cur_ff.mode[adc_seq_pkg::MODE_HW_START_BIT];
	assign mode_scan = cur_ff.mode[adc_seq_pkg::MODE_SCAN_BIT];

	// ----------------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------------
	// Computes the bus slave, the mode register and the conversion engine.
	always_comb begin
		logic wr_go;
		logic [2:0] nchan;
		logic [7:0] trial;
		wr_go = 1'b0;
		nchan = 3'h0;
		trial = 8'h00;
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		nxt_ff.trig_prev = external_trigger_pin_i;

		// Write address and data are taken in either order.
		if (s_axi_awvalid_i && cur_ff.awready) begin
			nxt_ff.aw_got = 1'b1;
			nxt_ff.aw_addr = s_axi_awaddr_i;
			nxt_ff.awready = 1'b0;
		end
		if (s_axi_wvalid_i && cur_ff.wready) begin
			nxt_ff.w_got = 1'b1;
			nxt_ff.w_data = s_axi_wdata_i;
			nxt_ff.w_strb = s_axi_wstrb_i;
			nxt_ff.wready = 1'b0;
		end
		wr_go = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid;
		if (wr_go) begin
			nxt_ff.aw_got = 1'b0;
			nxt_ff.w_got = 1'b0;
			nxt_ff.bvalid = 1'b1;
			nxt_ff.bresp = 2'h0;
			if (cur_ff.aw_addr[7:2] == adc_seq_pkg::MODE_OFS[7:2]) begin
				if (cur_ff.w_strb[0]) begin
					nxt_ff.mode = cur_ff.w_data[6:0];
				end
			end else if (cur_ff.aw_addr[7:2] != adc_seq_pkg::RESULT_OFS[7:2] &&
					cur_ff.aw_addr[7:2] != adc_seq_pkg::STATUS_OFS[7:2]) begin
				nxt_ff.bresp = 2'h2;
			end
		end
		if (cur_ff.bvalid && s_axi_bready_i) begin
			nxt_ff.bvalid = 1'b0;
			nxt_ff.awready = 1'b1;
			nxt_ff.wready = 1'b1;
		end

		// Reads answer one cycle after the address is taken.
		if (s_axi_arvalid_i && cur_ff.arready) begin
			nxt_ff.arready = 1'b0;
			nxt_ff.rvalid = 1'b1;
			nxt_ff.rresp = 2'h0;
			nxt_ff.rdata = 32'h0000_0000;
			unique case (s_axi_araddr_i[7:2])
				adc_seq_pkg::MODE_OFS[7:2]: nxt_ff.rdata[6:0] = cur_ff.mode;
				adc_seq_pkg::RESULT_OFS[7:2]: nxt_ff.rdata[7:0] = cur_ff.result;
				adc_seq_pkg::STATUS_OFS[7:2]: begin
					nxt_ff.rdata[0] = (cur_ff.state == ST_CONV);
					nxt_ff.rdata[6:4] = cur_ff.chan;
				end
				default: nxt_ff.rresp = 2'h2;
			endcase
		end
		if (cur_ff.rvalid && s_axi_rready_i) begin
			nxt_ff.rvalid = 1'b0;
			nxt_ff.arready = 1'b1;
		end

		// Scan wraps from the last channel of the group back to channel zero.
		nchan = mode_scan ? ((cur_ff.chan >= mode_chan) ? 3'h0 : cur_ff.chan + 3'h1) :
			mode_chan;

		unique case (cur_ff.state)
			ST_IDLE: begin
				if (mode_run) begin
					nxt_ff.chan = mode_scan ? 3'h0 : mode_chan;
					nxt_ff.state = mode_hw ? ST_WAIT : ST_CONV;
					nxt_ff.bit_idx = 3'h7;
					nxt_ff.sar = 8'h00;
					nxt_ff.cyc = 8'h00;
				end
			end
			ST_WAIT: begin
				if (external_trigger_pin_i && !cur_ff.trig_prev) begin
					nxt_ff.state = ST_CONV;
				end
			end
			ST_CONV: begin
				trial = cur_ff.sar | (8'h01 << cur_ff.bit_idx);
				if (cur_ff.cyc == 8'(adc_seq_pkg::CYCLES_PER_BIT - 1)) begin
					nxt_ff.cyc = 8'h00;
					nxt_ff.sar = cmp_i ? trial : cur_ff.sar;
					if (cur_ff.bit_idx == 3'h0) begin
						nxt_ff.result = cmp_i ? trial : cur_ff.sar;
						nxt_ff.done = 1'b1;
						nxt_ff.chan = nchan;
						nxt_ff.sar = 8'h00;
						nxt_ff.bit_idx = 3'h7;
					end else begin
						nxt_ff.bit_idx = cur_ff.bit_idx - 3'h1;
					end
				end else begin
					nxt_ff.cyc = cur_ff.cyc + 8'h01;
				end
			end
			default: nxt_ff.state = ST_IDLE;
		endcase
		if (!mode_run) begin
			nxt_ff.state = ST_IDLE;
		end

		// Outputs: one-hot input select and trial code.
		nxt_ff.sel = 8'h01 << nxt_ff.chan;
		nxt_ff.code = (nxt_ff.state == ST_CONV) ?
			(nxt_ff.sar | (8'h01 << nxt_ff.bit_idx)) : 8'h00;
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	// Registers the whole state on each clock.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cur_ff <= '0;
			cur_ff.awready <= 1'b1;
			cur_ff.wready <= 1'b1;
			cur_ff.arready <= 1'b1;
			cur_ff.mode <= adc_seq_pkg::MODE_RESET;
			cur_ff.result <= adc_seq_pkg::RESULT_RESET;
			cur_ff.state <= ST_IDLE;
			cur_ff.sel <= 8'h01;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign s_axi_awready_o = cur_ff.awready;
	assign s_axi_wready_o = cur_ff.wready;
	assign s_axi_bvalid_o = cur_ff.bvalid;
	assign s_axi_bresp_o = cur_ff.bresp;
	assign s_axi_arready_o = cur_ff.arready;
	assign s_axi_rvalid_o = cur_ff.rvalid;
	assign s_axi_rresp_o = cur_ff.rresp;
	assign s_axi_rdata_o = cur_ff.rdata;
	assign analog_input_pins_sel_o = cur_ff.sel;
	assign dac_code_o = cur_ff.code;
	assign conversion_done_interrupt_o = cur_ff.done;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	sequence last_bit_s;
		cur_ff.state == ST_CONV && cur_ff.bit_idx == 3'h0 &&
			cur_ff.cyc == 8'(adc_seq_pkg::CYCLES_PER_BIT - 1) && mode_run;
	endsequence

	// Counts converting cycles since the last done pulse or since the start.
	// The period is then checked on this count and not by one long delay.
	logic [9:0] conv_len_ff;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_len_ff <= 10'h000;
		end else if (cur_ff.state != ST_CONV) begin
			conv_len_ff <= 10'h000;
		end else if (conversion_done_interrupt_o) begin
			conv_len_ff <= 10'h001;
		end else if (conv_len_ff != 10'h3FF) begin
			conv_len_ff <= conv_len_ff + 10'h001;
		end
	end

	one_hot_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$onehot(analog_input_pins_sel_o)) else $error("Select is not one-hot.");
	done_on_result_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		last_bit_s |=> conversion_done_interrupt_o) else $error("Done pulse missing.");
	done_one_cycle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		conversion_done_interrupt_o |=> !conversion_done_interrupt_o) else $error("Done too long.");
	result_latched_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		last_bit_s |=> cur_ff.result == $past(cmp_i ? (cur_ff.sar | 8'h01) : cur_ff.sar))
		else $error("Result not latched.");
	conv_period_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		conversion_done_interrupt_o |-> conv_len_ff == 10'(adc_seq_pkg::CONV_CYCLES))
		else $error("Conversion period wrong.");
	hw_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cur_ff.state == ST_WAIT && !(external_trigger_pin_i && !cur_ff.trig_prev) && mode_run
		|=> cur_ff.state == ST_WAIT) else $error("Started without trigger.");
	sw_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cur_ff.state == ST_IDLE && mode_run && !mode_hw |=> cur_ff.state == ST_CONV)
		else $error("Software start ignored.");
	select_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(last_bit_s and !mode_scan) |=> cur_ff.chan == $past(mode_chan))
		else $error("Select moved.");
	scan_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(last_bit_s and (mode_scan && cur_ff.chan < mode_chan)) |=>
		cur_ff.chan == $past(cur_ff.chan) + 3'h1)
		else $error("Scan did not step.");
	scan_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(last_bit_s and (mode_scan && cur_ff.chan >= mode_chan)) |=> cur_ff.chan == 3'h0)
		else $error("Scan did not wrap.");
	stop_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!mode_run |=> cur_ff.state == ST_IDLE) else $error("Stop ignored.");

endmodule : adc_conversion_sequencer

// File: verification/analog_src_model.sv
/*
 * Model of the analog sources and comparator on the far side of the sequencer.
 * Assumes levels_i holds one 8-bit level per channel, channel n in bits 8n+7:8n.
 */
`timescale 1ns/1ps
module analog_src_model (
	// Levels, select and trial code.
	input wire logic [63:0] levels_i,
	input wire logic [7:0] sel_i,
	input wire logic [7:0] code_i,
	// Comparator answer.
	output logic cmp_o
);
	logic [7:0] lvl;
	// Routes the selected channel and compares it with the trial code in the same cycle.
	always_comb begin
		lvl = 8'h00;
		for (int n = 0; n < 8; n++) begin
			if (sel_i[n]) begin
				lvl = lvl | levels_i[8*n +: 8];
			end
		end
		cmp_o = (lvl >= code_i);
	end
endmodule : analog_src_model

// File: verification/tb_top.sv
/*
 * Self-checking bench for the conversion sequencer.
 * Assumes a 40 MHz clock, the AXI4-Lite map of the package and a same-cycle comparator.
 */
`timescale 1ns/1ps
module tb_top;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, trig = 1'b0, cmp;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, sel, code;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, done;
	logic [1:0] bresp, rresp, r;
	logic [31:0] d;
	logic [63:0] levels = 64'hE1_9A_73_5C_C8_2F_B4_46;
	int n_errors = 0, n_compared = 0, cyc;
	// ----------------------------------------------------------------------
	// Design and far side
	// ----------------------------------------------------------------------
	adc_conversion_sequencer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .external_trigger_pin_i(trig),
		.cmp_i(cmp), .analog_input_pins_sel_o(sel), .dac_code_o(code),
		.conversion_done_interrupt_o(done));
	analog_src_model src_u (.levels_i(levels), .sel_i(sel), .code_i(code), .cmp_o(cmp));
	// Clock of 25 ns period.
	always #12.5 mclk_i = ~mclk_i;
	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	// Compares a seen value with the expected one and counts the result.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Writes one word, waiting for both takes and then the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (awvalid & awready) awvalid <= 1'b0;
			if (wvalid & wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1));
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	// Reads one word and keeps data and response.
	task automatic rd(input logic [7:0] a);
		@(posedge mclk_i);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (arvalid & arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1));
		d = rdata; r = rresp;
		rready <= 1'b0;
	endtask : rd
	// Counts edges until the done pulse is sampled or the limit runs out.
	task automatic wait_done(input int lim);
		cyc = 0;
		do begin
			@(posedge mclk_i);
			cyc++;
		end while (!(done === 1'b1) && cyc < lim);
	endtask : wait_done
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	// Reset values and the unmapped address.
	task automatic t_reset();
		rd(adc_seq_pkg::MODE_OFS); check("mode_reset", d, 32'h0);
		rd(adc_seq_pkg::RESULT_OFS); check("result_reset", d, 32'h0);
		rd(8'h0C); check("unmapped_rresp", {30'h0, r}, 32'h2);
		wr(8'h0C, 32'h1); check("unmapped_bresp", {30'h0, r}, 32'h2);
		wr(adc_seq_pkg::RESULT_OFS, 32'h5A); rd(adc_seq_pkg::RESULT_OFS);
		check("result_ro", d, 32'h0);
		$display("Test reset done");
	endtask : t_reset
	// Software start in select mode on channel 3, two results in a row.
	task automatic t_select();
		wr(adc_seq_pkg::MODE_OFS, 32'h31);
		for (int i = 0; i < 2; i++) begin
			wait_done(1000);
			if (i == 0) check("conv_time", 32'(cyc >= 398 && cyc <= 404), 32'h1);
			check("select_sel", {24'h0, sel}, 32'h08);
			rd(adc_seq_pkg::RESULT_OFS);
			check("select_result", d, {24'h0, levels[31:24]});
		end
		rd(adc_seq_pkg::MODE_OFS); check("mode_readback", d, 32'h31);
		rd(adc_seq_pkg::STATUS_OFS); check("status_select", d, 32'h31);
		wr(adc_seq_pkg::MODE_OFS, 32'h0);
		$display("Test select done");
	endtask : t_select
	// Scan over channels 0 to 2 with the wrap back to channel 0.
	task automatic t_scan();
		wr(adc_seq_pkg::MODE_OFS, 32'h25);
		for (int i = 0; i < 4; i++) begin
			wait_done(1000);
			check("scan_done", {31'h0, done}, 32'h1);
			rd(adc_seq_pkg::RESULT_OFS);
			check("scan_result", d, {24'h0, levels[8*(i%3) +: 8]});
		end
		wr(adc_seq_pkg::MODE_OFS, 32'h0);
		$display("Test scan done");
	endtask : t_scan
	// Clearing run mid-conversion gives no result.
	task automatic t_stop();
		wr(adc_seq_pkg::MODE_OFS, 32'h11);
		repeat (100) @(posedge mclk_i);
		wr(adc_seq_pkg::MODE_OFS, 32'h0);
		wait_done(600); check("stop_no_done", {31'h0, done}, 32'h0);
		check("stop_code", {24'h0, code}, 32'h0);
		$display("Test stop done");
	endtask : t_stop
	// Hardware start waits for the trigger edge.
	task automatic t_hw();
		wr(adc_seq_pkg::MODE_OFS, 32'h03);
		wait_done(500); check("hw_wait", {31'h0, done}, 32'h0);
		trig <= 1'b1;
		@(posedge mclk_i);
		trig <= 1'b0;
		wait_done(1000); check("hw_done", {31'h0, done}, 32'h1);
		rd(adc_seq_pkg::RESULT_OFS); check("hw_result", d, {24'h0, levels[7:0]});
		wr(adc_seq_pkg::MODE_OFS, 32'h0);
		$display("Test hardware start done");
	endtask : t_hw
	// Main sequence after a 20-cycle reset.
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_reset(); t_select(); t_scan(); t_stop(); t_hw();
		complete_run();
	end
	// Watchdog well past the expected run length.
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		complete_run();
	end
endmodule : tb_top
